// *** include/pdc_params.svh ***
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH
`define PDC_OFF_DEVCAP   8'hc4
`define PDC_OFF_DEVCTL   8'hc8
`define PDC_MPS_128      3'h0
`define PDC_MPS_256      3'h1
`define PDC_MPS_512      3'h2
`define PDC_RBER_RST     1'b1
`define PDC_AUX_PWR      1'b1
`define PDC_LAT_RST      3'h0
`define PDC_SPL_VAL_RST  8'h00
`define PDC_SPL_SCL_RST  2'h0
`define PDC_EN_LO        0
`define PDC_EN_HI        3
`define PDC_MPSC_LO      5
`define PDC_MPSC_HI      7
`define PDC_ST_LO        16
`define PDC_ST_HI        19
`endif

// *** include/pdc_pkg.sv ***
package pdc_pkg;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pdc_cfg_req_s;
  typedef struct packed {
    logic [2:0] mps;
    logic       rber;
  } pdc_load_s;
  typedef struct packed {
    logic [7:0] value;
    logic [1:0] scale;
  } pdc_spl_s;
  typedef enum logic [1:0] {
    PDC_SYNC0 = 2'b00,
    PDC_SYNC1 = 2'b01,
    PDC_RUN   = 2'b11
  } pdc_state_e;
endpackage : pdc_pkg

// *** logic/pdc_regs.sv ***
`timescale 1ns/1ns
`include "pdc_params.svh"
// Function
// - Capability bits 2:0 report payload: 000b 128, 001b 256, 010b 512.
// - At reset payload field is 001b with strap low, 010b with strap high.
// - Sideband or EEPROM loader may replace payload field and role bit.
// - Capability bit 15 reads one after reset and is read-only.
// - Capability bits 4:3 always read 00b.
// - Capability bit 5 always reads zero.
// - Latency fields 8:6 and 11:9 are read-only, reset 000b.
// - Upstream bits 25:18 capture slot power limit value, reset 00h.
// - Upstream bits 27:26 capture slot power limit scale, reset 00b.
// - Control bit 0 read-write correctable error enable, resets zero.
// - Control bit 1 read-write non-fatal error enable, resets zero.
// - Control bit 2 read-write fatal error enable, resets zero.
// - Control bit 3 read-write unsupported request enable, resets zero.
// - Detected flags set regardless of enables; cleared by writing one.
// - Payload control write above capability is clamped to capability.
module pdc_regs #(
  parameter bit IS_UPSTREAM = 1'b1
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 large_payload_strap,
  input  wire logic                 cfg_req_valid,
  input  wire pdc_pkg::pdc_cfg_req_s cfg_req,
  output logic                      cfg_rsp_valid,
  output logic [31:0]               cfg_rdata,
  input  wire logic                 ld_valid,
  input  wire pdc_pkg::pdc_load_s   ld,
  input  wire logic                 spl_valid,
  input  wire pdc_pkg::pdc_spl_s    spl,
  input  wire logic [3:0]           err_det,
  output logic [3:0]                err_msg,
  output logic [2:0]                mps_ctl
);
  logic                rst_s1_ff;
  logic                rst_sync_n;
  logic                strap_s1_ff;
  logic                strap_s2_ff;
  pdc_pkg::pdc_state_e state_ff,     nxt_state;
  logic [2:0]          mps_sup_ff,   nxt_mps_sup;
  logic                rber_ff,      nxt_rber;
  pdc_pkg::pdc_spl_s   spl_ff,       nxt_spl;
  logic [3:0]          en_ff,        nxt_en;
  logic [2:0]          mps_ctl_ff,   nxt_mps_ctl;
  logic [3:0]          st_ff,        nxt_st;
  logic                rsp_ff,       nxt_rsp;
  logic [31:0]         rdata_ff,     nxt_rdata;
  logic [3:0]          msg_ff,       nxt_msg;
  logic                run;
  logic                wr_cap;
  logic                wr_ctl;
  logic [2:0]          mps_wr;
  logic [31:0]         cap_word;
  logic [31:0]         ctl_word;

  if (IS_UPSTREAM !== 1'b0 && IS_UPSTREAM !== 1'b1) begin : g_chk
    $error("IS_UPSTREAM must be 0 or 1");
  end

  // Reset release and strap pin both cross in through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff  <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_ff  <= 1'b1;
      rst_sync_n <= rst_s1_ff;
    end
  end

  // No reset here: chain must hold the strap before SYNC1 samples it
  always_ff @(posedge core_clk) begin
    strap_s1_ff <= large_payload_strap;
    strap_s2_ff <= strap_s1_ff;
  end

  assign run    = (state_ff == pdc_pkg::PDC_RUN);
  assign wr_cap = run && cfg_req_valid && cfg_req.wr
                  && (cfg_req.addr == `PDC_OFF_DEVCAP);
  assign wr_ctl = run && cfg_req_valid && cfg_req.wr
                  && (cfg_req.addr == `PDC_OFF_DEVCTL);
  assign mps_wr = cfg_req.wdata[`PDC_MPSC_HI:`PDC_MPSC_LO];

  assign cap_word = {4'h0, spl_ff.scale, spl_ff.value, 2'h0,
                     rber_ff, 3'h0,
                     `PDC_LAT_RST, `PDC_LAT_RST,
                     1'b0, 2'h0,
                     mps_sup_ff};
  assign ctl_word = {10'h000, 1'b0, `PDC_AUX_PWR, st_ff,
                     8'h00, mps_ctl_ff, 1'b0, en_ff};

  always_comb begin
    nxt_state   = state_ff;
    nxt_mps_sup = mps_sup_ff;
    nxt_rber    = rber_ff;
    nxt_spl     = spl_ff;
    nxt_en      = en_ff;
    nxt_mps_ctl = mps_ctl_ff;
    nxt_rsp     = 1'b0;
    nxt_rdata   = 32'h0000_0000;
    // Synchroniser must settle before the strap is trusted
    case (state_ff)
      pdc_pkg::PDC_SYNC0: nxt_state = pdc_pkg::PDC_SYNC1;
      pdc_pkg::PDC_SYNC1: begin
        nxt_state   = pdc_pkg::PDC_RUN;
        nxt_mps_sup = strap_s2_ff ? `PDC_MPS_512 : `PDC_MPS_256;
      end
      default: nxt_state = pdc_pkg::PDC_RUN;
    endcase
    if (run && ld_valid) begin
      nxt_mps_sup = ld.mps;
      nxt_rber    = ld.rber;
    end
    if (IS_UPSTREAM && run && spl_valid) begin
      nxt_spl = spl;
    end
    if (wr_ctl && cfg_req.be[0]) begin
      nxt_en = cfg_req.wdata[`PDC_EN_HI:`PDC_EN_LO];
      // Clamp uses the capability as it stands now
      nxt_mps_ctl = (mps_wr > mps_sup_ff) ? mps_sup_ff : mps_wr;
    end
    if (run && cfg_req_valid) begin
      nxt_rsp = 1'b1;
      if (!cfg_req.wr) begin
        if (cfg_req.addr == `PDC_OFF_DEVCAP) begin
          nxt_rdata = cap_word;
        end else if (cfg_req.addr == `PDC_OFF_DEVCTL) begin
          nxt_rdata = ctl_word;
        end else begin
          nxt_rdata = 32'h0000_0000;
        end
      end
    end
  end

  // Set beats clear so an error in the clearing cycle is kept
  always_comb begin
    nxt_st = st_ff;
    if (wr_ctl && cfg_req.be[2]) begin
      nxt_st = st_ff & ~cfg_req.wdata[`PDC_ST_HI:`PDC_ST_LO];
    end
    nxt_st  = nxt_st | err_det;
    nxt_msg = err_det & en_ff;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff   <= pdc_pkg::PDC_SYNC0;
      mps_sup_ff <= `PDC_MPS_256;
      rber_ff    <= `PDC_RBER_RST;
      spl_ff     <= {`PDC_SPL_VAL_RST, `PDC_SPL_SCL_RST};
      en_ff      <= 4'h0;
      mps_ctl_ff <= `PDC_MPS_128;
      st_ff      <= 4'h0;
      rsp_ff     <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      msg_ff     <= 4'h0;
    end else begin
      state_ff   <= nxt_state;
      mps_sup_ff <= nxt_mps_sup;
      rber_ff    <= nxt_rber;
      spl_ff     <= nxt_spl;
      en_ff      <= nxt_en;
      mps_ctl_ff <= nxt_mps_ctl;
      st_ff      <= nxt_st;
      rsp_ff     <= nxt_rsp;
      rdata_ff   <= nxt_rdata;
      msg_ff     <= nxt_msg;
    end
  end

  assign cfg_rsp_valid = rsp_ff;
  assign cfg_rdata     = rdata_ff;
  assign err_msg       = msg_ff;
  assign mps_ctl       = mps_ctl_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  property p_mps_legal;
    run |-> (mps_sup_ff <= `PDC_MPS_512) || $past(ld_valid);
  endproperty
  a_mps_legal: assert property (p_mps_legal)
    else $error("payload capability holds reserved code");

  property p_strap;
    (state_ff == pdc_pkg::PDC_SYNC1) |=> (mps_sup_ff ==
      ($past(large_payload_strap, 3) ? `PDC_MPS_512 : `PDC_MPS_256));
  endproperty
  a_strap: assert property (p_strap)
    else $error("payload capability not taken from strap");

  property p_load;
    (run && ld_valid) |=> (mps_sup_ff == $past(ld.mps))
      && (rber_ff == $past(ld.rber));
  endproperty
  a_load: assert property (p_load)
    else $error("loader value not applied");

  property p_rber_ro;
    (wr_cap && !ld_valid) |=> $stable(rber_ff) && $stable(mps_sup_ff);
  endproperty
  a_rber_ro: assert property (p_rber_ro)
    else $error("read-only capability changed by write");

  property p_cap_fixed;
    (run && cfg_req_valid && !cfg_req.wr
      && cfg_req.addr == `PDC_OFF_DEVCAP)
      |=> cfg_rsp_valid && (cfg_rdata[11:3] == 9'h000)
          && (cfg_rdata[31:28] == 4'h0) && (cfg_rdata[17:16] == 2'h0);
  endproperty
  a_cap_fixed: assert property (p_cap_fixed)
    else $error("fixed capability bits not zero");

  property p_spl;
    (run && spl_valid) |=> (spl_ff == (IS_UPSTREAM ? $past(spl)
                                                    : $past(spl_ff)));
  endproperty
  a_spl: assert property (p_spl)
    else $error("slot power limit not captured");

  property p_en;
    (wr_ctl && cfg_req.be[0]) |=> (en_ff == $past(cfg_req.wdata[3:0]));
  endproperty
  a_en: assert property (p_en)
    else $error("error reporting enables not written");

  property p_err;
    (err_det != 4'h0) |=> ((st_ff & $past(err_det)) == $past(err_det));
  endproperty
  a_err: assert property (p_err)
    else $error("detected error flag lost");

  property p_clamp;
    (wr_ctl && cfg_req.be[0] && (mps_wr > mps_sup_ff))
      |=> (mps_ctl_ff == $past(mps_sup_ff));
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("payload control not clamped");

  c_strap_high: cover property ((state_ff == pdc_pkg::PDC_SYNC1)
                                && strap_s2_ff);
  c_clamp: cover property (wr_ctl && (mps_wr > mps_sup_ff));
  c_err_clr: cover property (wr_ctl && cfg_req.be[2] && (err_det != 4'h0));
  c_spl: cover property (run && spl_valid);
endmodule : pdc_regs

// *** tb/pdc_host.sv ***
`timescale 1ns/1ns
// Host configuration software: one request at a time, caller byte enables
module pdc_host (
  input  wire logic                  core_clk,
  output logic                       cfg_req_valid,
  output pdc_pkg::pdc_cfg_req_s      cfg_req,
  input  wire logic                  cfg_rsp_valid,
  input  wire logic [31:0]           cfg_rdata
);
  int unsigned gap = 0;
  initial begin
    cfg_req_valid = 1'b0;
    cfg_req       = '0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] wd,
                      output logic [31:0] rd);
    // Optional idle cycles model a slow host
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    cfg_req_valid <= 1'b1;
    cfg_req       <= '{wr: wr, addr: a, be: be, wdata: wd};
    @(posedge core_clk);
    cfg_req_valid <= 1'b0;
    // Released fields carry junk, not the last request
    cfg_req       <= ~cfg_req;
    @(posedge core_clk);
    rd = (cfg_rsp_valid === 1'b1) ? cfg_rdata : 32'hdead_beef;
  endtask : xfer
endmodule : pdc_host

// *** tb/pdc_regs_tb_top.sv ***
`timescale 1ns/1ns
module pdc_regs_tb_top;
  logic                  core_clk = 1'b0;
  logic                  rst_n    = 1'b0;
  logic                  strap    = 1'b1;
  logic                  req_v;
  pdc_pkg::pdc_cfg_req_s req;
  logic                  rsp_v;
  logic [31:0]           rdata;
  logic                  ld_valid  = 1'b0;
  pdc_pkg::pdc_load_s    ld        = '0;
  logic                  spl_valid = 1'b0;
  pdc_pkg::pdc_spl_s     spl       = '0;
  logic [3:0]            err_det   = 4'h0;
  logic [3:0]            err_msg;
  logic [2:0]            mps_ctl;
  int                    miscompares = 0;
  int                    checked     = 0;
  int                    cyc         = 0;
  logic [31:0]           rd;
  logic [31:0]           rdata_dn;
  always #5 core_clk = ~core_clk;
  pdc_regs DUT (.core_clk(core_clk), .rst_n(rst_n),
    .large_payload_strap(strap), .cfg_req_valid(req_v), .cfg_req(req),
    .cfg_rsp_valid(rsp_v), .cfg_rdata(rdata), .ld_valid(ld_valid),
    .ld(ld), .spl_valid(spl_valid), .spl(spl), .err_det(err_det),
    .err_msg(err_msg), .mps_ctl(mps_ctl));
  // Downstream copy shares every input; it must ignore slot power
  pdc_regs #(.IS_UPSTREAM(1'b0)) DUT_DN (.core_clk(core_clk),
    .rst_n(rst_n), .large_payload_strap(strap), .cfg_req_valid(req_v),
    .cfg_req(req), .cfg_rsp_valid(), .cfg_rdata(rdata_dn),
    .ld_valid(ld_valid), .ld(ld), .spl_valid(spl_valid), .spl(spl),
    .err_det(err_det), .err_msg(), .mps_ctl());
  pdc_host host (.core_clk(core_clk), .cfg_req_valid(req_v),
    .cfg_req(req), .cfg_rsp_valid(rsp_v), .cfg_rdata(rdata));
  task automatic chk(input logic [31:0] seen, exp, input string m);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s saw %h want %h", $time, m, seen, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 4'hf, 32'h0, rd);
    chk(rd, exp, "read");
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    host.xfer(1'b1, a, be, d, rd);
    chk(rd, 32'h0, "write answer");
  endtask : wr
  task automatic do_reset(input logic s);
    @(posedge core_clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    // Strap needs the sync stages before the first request
    repeat (6) @(posedge core_clk);
  endtask : do_reset
  task automatic t_ro;
    wr(8'hc4, 4'hf, 32'hffff_ffff);
    rd_chk(8'hc4, 32'h0000_8002);
    rd_chk(8'hc0, 32'h0);
  endtask : t_ro
  task automatic t_err;
    for (int i = 0; i < 4; i++) begin
      wr(8'hc8, 4'h1, 32'h1 << i);
      @(posedge core_clk);
      err_det <= 4'hf;
      @(posedge core_clk);
      err_det <= 4'h0;
      @(posedge core_clk);
      chk({28'h0, err_msg}, 32'h1 << i, "err msg");
      rd_chk(8'hc8, 32'h001f_0000 | (32'h1 << i));
      wr(8'hc8, 4'h4, 32'h000f_0000);
      rd_chk(8'hc8, 32'h0010_0000 | (32'h1 << i));
    end
  endtask : t_err
  task automatic t_clamp;
    wr(8'hc8, 4'h1, 32'h0000_00e0);
    chk({29'h0, mps_ctl}, 32'h2, "clamp");
    rd_chk(8'hc8, 32'h0010_0040);
    wr(8'hc8, 4'h1, 32'h0000_0020);
    chk({29'h0, mps_ctl}, 32'h1, "mps ctl");
  endtask : t_clamp
  // Clear and new error in one cycle: the new flag must survive
  task automatic t_race;
    fork
      wr(8'hc8, 4'h4, 32'h000f_0000);
      begin
        @(posedge core_clk);
        err_det <= 4'h2;
        @(posedge core_clk);
        err_det <= 4'h0;
      end
    join
    rd_chk(8'hc8, 32'h0012_0020);
    wr(8'hc8, 4'h4, 32'h000f_0000);
    rd_chk(8'hc8, 32'h0010_0020);
  endtask : t_race
  task automatic t_side;
    @(posedge core_clk);
    spl_valid <= 1'b1;
    spl       <= '{value: 8'ha5, scale: 2'h3};
    @(posedge core_clk);
    spl_valid <= 1'b0;
    spl       <= '0;
    rd_chk(8'hc4, 32'h0e94_8002);
    chk(rdata_dn, 32'h0000_8002, "downstream spl");
    ld_valid <= 1'b1;
    ld       <= '{mps: 3'h0, rber: 1'b0};
    @(posedge core_clk);
    ld_valid <= 1'b0;
    ld       <= '{mps: 3'h7, rber: 1'b1};
    rd_chk(8'hc4, 32'h0e94_0000);
  endtask : t_side
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  // Whole run is well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    do_reset(1'b1);
    rd_chk(8'hc4, 32'h0000_8002);
    rd_chk(8'hc8, 32'h0010_0000);
    chk({29'h0, mps_ctl}, 32'h0, "mps reset");
    t_ro();
    host.gap = 3;
    t_err();
    host.gap = 0;
    t_clamp();
    t_race();
    t_side();
    do_reset(1'b0);
    rd_chk(8'hc4, 32'h0000_8001);
    wrap_up();
  end
endmodule : pdc_regs_tb_top
